//--- logic/sent_payload_pkg.sv
package sent_payload_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_OFS         = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;
  localparam logic [7:0]  CUST_OFS        = 8'h08;
  localparam logic [7:0]  FRAME_OFS       = 8'h0C;

  localparam int          CFG_SS_DIS_BIT  = 0;
  localparam int          CFG_LAYOUT_LSB  = 1;
  localparam int          CFG_ADDR_IN_BIT = 3;
  localparam int          CFG_SCN_CRC_BIT = 4;
  localparam int          CFG_FALL_LSB    = 5;
  localparam int          CFG_MODE_LSB    = 8;
  localparam int          CFG_BUSADR_LSB  = 11;
  localparam logic [12:0] CFG_RESET       = 13'h0000;
  localparam logic [23:0] CUST_RESET      = 24'h00_0000;

  // ----------------------------------------------------------------
  // frame and slow channel constants
  // ----------------------------------------------------------------
  localparam logic [3:0]  SLOT_LAST       = 4'hF;
  localparam logic [3:0]  SLOT_CRC_FIRST  = 4'hC;
  localparam logic [3:0]  MSG_ID_LAST     = 4'h4;
  localparam logic [3:0]  CRC_SEED        = 4'h5;
  localparam logic [3:0]  CRC_POLY        = 4'hD;
  localparam logic [2:0]  LOW_TICKS       = 3'h5;
  localparam logic [4:0]  HIGH_TICKS_BASE = 5'h07;
  localparam logic [11:0] CNT_MAX_SHORT   = 12'h00F;
  localparam logic [3:0]  LEN_SHORT       = 4'h5;
  localparam logic [3:0]  LEN_LONG        = 4'h8;
  localparam logic [10:0] TEMP_OFFSET     = 11'h019;
  localparam logic [12:0] TEMP_ROUND      = 13'h0004;

  typedef enum logic [1:0] {
    LAYOUT_FIELD,
    LAYOUT_FLAGS,
    LAYOUT_COUNT,
    LAYOUT_TEMP
  } layout_t;

  typedef enum logic [2:0] {
    MODE_PLAIN,
    MODE_SEQUENTIAL,
    MODE_ADDRESSED
  } line_mode_t;

  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } tx_state_t;

  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    logic       fb;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      fb = r[3] ^ n[i];
      r  = {r[2:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction : crc_step

endpackage : sent_payload_pkg

//--- logic/sent_frame_payload_builder.sv
`timescale 1ns/100ps
// Behaviour
// RL1 - slow channel rides in status bits only while its disable bit is zero
// RL2 - message ids run 0,1,2,3,4 from reset, then wrap to 0
// RL3 - message spans 16 frames; start bit first frame; id, data, checksum
// RL4 - message checksum covers id and data, same algorithm as frame crc
// RL5 - message 0 carries the eight error-status flags
// RL6 - message 1 carries die temperature, rounded, saturated to 8 bits
// RL7 - messages 2,3,4 carry customer identifier bytes low to high
// RL8 - shared modes, slow channel off, address bit set: address in bits 3:2
// RL9 - layout code picks field, flags+counter, counter or temperature nibbles
// RL10 - frame has 3 data nibbles for layout 0, otherwise 6
// RL11 - frame counter steps once per frame; wraps at 15 or 4095
// RL12 - temperature payload is signed, 8 lsb per degree, 25 degree offset
// RL13 - fault flag byte order fixed, memory error down to range high
// RL14 - frame crc over data nibbles, polynomial x4+x3+x2+1, seed 0101
// RL15 - shared modes may fold the status nibble into the crc first
// RL16 - 3-bit fall-time code, reset 0, drives the output gate ramp
// RL17 - status bits 1:0 always carry device status code
// RL18 - every nibble is 5 low ticks then value-coded high ticks
// RL19 - slow message content captured at sequence start, held to its end
// RL20 - all frame payload fields sampled in one cycle
module sent_frame_payload_builder
  import sent_payload_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              frame_start,
  input  wire logic [11:0]       mag_out,
  input  wire logic [7:0]        diag_flags,
  input  wire logic [11:0]       temp_out,
  input  wire logic [1:0]        device_status,
  output logic                   nibble_valid,
  input  wire logic              nibble_ready,
  output logic      [3:0]        nibble_value,
  output logic                   nibble_last,
  output logic      [2:0]        nibble_low_ticks,
  output logic      [4:0]        nibble_high_ticks,
  output logic      [2:0]        fall_time_sel
);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [12:0] cfg_q;
  logic [23:0] cust_q;
  logic [31:0] prdata_q;
  logic        err_q;
  logic [3:0]  slot_q;
  logic [3:0]  msg_id_q;
  logic [11:0] cnt_q;
  logic [3:0]  seq_q [0:7];
  logic [3:0]  len_q;
  logic [3:0]  idx_q;
  logic [3:0]  nib_q;
  tx_state_t   state_q;
  logic [11:0] msg_q;
  logic [3:0]  msg_crc_q;

  logic [7:0]  addr8;
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic [31:0] wmask;

  assign addr8   = paddr[7:0];
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign mapped  = (addr8 == CFG_OFS) || (addr8 == STAT_OFS) ||
                   (addr8 == CUST_OFS) || (addr8 == FRAME_OFS);
  assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = psel && penable && err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      err_q    <= !mapped;
      prdata_q <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (addr8)
          CFG_OFS:   prdata_q <= {19'h0_0000, cfg_q};
          STAT_OFS:  prdata_q <= {12'h000, cnt_q, slot_q, msg_id_q};
          CUST_OFS:  prdata_q <= {8'h00, cust_q};
          FRAME_OFS: prdata_q <= {seq_q[7], seq_q[6], seq_q[5], seq_q[4],
                                  seq_q[3], seq_q[2], seq_q[1], seq_q[0]};
          default:   prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q  <= CFG_RESET; // RL16
      cust_q <= CUST_RESET;
    end else if (wr_acc && !err_q) begin
      if (addr8 == CFG_OFS) begin
        cfg_q <= (cfg_q & ~wmask[12:0]) | (pwdata[12:0] & wmask[12:0]);
      end
      if (addr8 == CUST_OFS) begin
        cust_q <= (cust_q & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  logic       ss_dis;
  logic       addr_in;
  logic       scn_crc;
  logic       shared;
  layout_t    layout;
  line_mode_t mode;
  logic [1:0] bus_addr;

  assign ss_dis        = cfg_q[CFG_SS_DIS_BIT];
  assign addr_in       = cfg_q[CFG_ADDR_IN_BIT];
  assign scn_crc       = cfg_q[CFG_SCN_CRC_BIT];
  assign layout        = layout_t'(cfg_q[CFG_LAYOUT_LSB +: 2]);
  assign mode          = line_mode_t'(cfg_q[CFG_MODE_LSB +: 3]);
  assign bus_addr      = cfg_q[CFG_BUSADR_LSB +: 2];
  assign shared        = (mode == MODE_SEQUENTIAL) || (mode == MODE_ADDRESSED);
  assign fall_time_sel = cfg_q[CFG_FALL_LSB +: 3]; // RL16

  // ----------------------------------------------------------------
  // frame composition
  // ----------------------------------------------------------------
  logic        take;
  logic [7:0]  msg_data;
  logic [11:0] msg_cur;
  logic [3:0]  msg_crc_cur;
  logic        ss_bit;
  logic [3:0]  status_nib;
  logic [3:0]  dat [0:5];
  logic [3:0]  len_d;
  logic [3:0]  crc_d;
  logic [12:0] t_round;
  logic [10:0] deg;
  logic [7:0]  temp8;
  logic [11:0] tail;

  assign take = frame_start && (state_q == TX_IDLE);

  always_comb begin
    t_round = {temp_out[11], temp_out} + TEMP_ROUND; // RL6
    deg     = {t_round[12], t_round[12:3]} + TEMP_OFFSET;
    temp8   = (!deg[10] && (deg[9:7] != 3'h0)) ? 8'h7F : // RL6
              (deg[10] && (deg[9:7] != 3'h7)) ? 8'h80 : deg[7:0];
    unique case (msg_id_q)
      4'h0:    msg_data = diag_flags; // RL5
      4'h1:    msg_data = temp8; // RL6
      4'h2:    msg_data = cust_q[7:0]; // RL7
      4'h3:    msg_data = cust_q[15:8];
      4'h4:    msg_data = cust_q[23:16];
      default: msg_data = 8'h00;
    endcase
  end

  always_comb begin
    msg_cur     = (slot_q == 4'h0) ? {msg_id_q, msg_data} : msg_q; // RL19
    msg_crc_cur = crc_step(crc_step(crc_step(CRC_SEED, msg_cur[11:8]),
                                    msg_cur[7:4]), msg_cur[3:0]); // RL4
    if (slot_q == 4'h0) begin
      ss_bit = msg_cur[11];
    end else if (slot_q < SLOT_CRC_FIRST) begin
      ss_bit = msg_cur[4'hB - slot_q]; // RL3
    end else begin
      ss_bit = msg_crc_q[2'(SLOT_LAST - slot_q)];
    end
  end

  always_comb begin
    if (!ss_dis) begin
      status_nib = {slot_q == 4'h0, ss_bit, device_status}; // RL1 RL3 RL17
    end else if (shared && addr_in) begin
      status_nib = {bus_addr, device_status}; // RL8
    end else begin
      status_nib = {2'b00, device_status}; // RL17
    end
    dat[0] = mag_out[11:8]; // RL9 RL20
    dat[1] = mag_out[7:4];
    dat[2] = mag_out[3:0];
    unique case (layout)
      LAYOUT_FIELD: tail = 12'h000;
      LAYOUT_FLAGS: tail = {diag_flags, cnt_q[3:0]}; // RL13
      LAYOUT_COUNT: tail = cnt_q;
      LAYOUT_TEMP:  tail = temp_out; // RL12
    endcase
    dat[3] = tail[11:8];
    dat[4] = tail[7:4];
    dat[5] = tail[3:0];
    len_d = (layout == LAYOUT_FIELD) ? LEN_SHORT : LEN_LONG; // RL10
    crc_d = (shared && scn_crc) ? crc_step(CRC_SEED, status_nib) : CRC_SEED; // RL14 RL15
    for (int i = 0; i < 6; i++) begin
      if ((i < 3) || (layout != LAYOUT_FIELD)) begin
        crc_d = crc_step(crc_d, dat[i]); // RL14
      end
    end
  end

  // ----------------------------------------------------------------
  // frame storage and nibble sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        seq_q[i] <= 4'h0;
      end
      len_q <= LEN_SHORT;
    end else if (take) begin
      seq_q[0] <= status_nib; // RL20
      for (int i = 0; i < 6; i++) begin
        seq_q[i+1] <= dat[i];
      end
      seq_q[7] <= crc_d;
      if (layout == LAYOUT_FIELD) begin
        seq_q[4] <= crc_d;
      end
      len_q <= len_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TX_IDLE;
      idx_q   <= 4'h0;
      nib_q   <= 4'h0;
    end else if (take) begin
      state_q <= TX_SEND;
      idx_q   <= 4'h0;
      nib_q   <= status_nib;
    end else if ((state_q == TX_SEND) && nibble_ready) begin
      if (idx_q == len_q - 4'h1) begin
        state_q <= TX_IDLE;
      end else begin
        idx_q <= idx_q + 4'h1;
        nib_q <= seq_q[3'(idx_q + 4'h1)];
      end
    end
  end

  assign nibble_valid      = (state_q == TX_SEND);
  assign nibble_value      = nib_q;
  assign nibble_last       = nibble_valid && (idx_q == len_q - 4'h1);
  assign nibble_low_ticks  = LOW_TICKS; // RL18
  assign nibble_high_ticks = HIGH_TICKS_BASE + {1'b0, nib_q}; // RL18

  // ----------------------------------------------------------------
  // frame counter and slow channel sequence
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 12'h000;
    end else if (take) begin
      if ((layout == LAYOUT_FLAGS) && (cnt_q >= CNT_MAX_SHORT)) begin
        cnt_q <= 12'h000; // RL11
      end else begin
        cnt_q <= cnt_q + 12'h001; // RL11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q    <= 4'h0;
      msg_id_q  <= 4'h0; // RL2
      msg_q     <= 12'h000;
      msg_crc_q <= 4'h0;
    end else if (ss_dis) begin
      slot_q <= 4'h0;
    end else if (take) begin
      if (slot_q == 4'h0) begin
        msg_q     <= msg_cur; // RL19
        msg_crc_q <= msg_crc_cur;
      end
      slot_q <= slot_q + 4'h1;
      if (slot_q == SLOT_LAST) begin
        msg_id_q <= (msg_id_q == MSG_ID_LAST) ? 4'h0 : msg_id_q + 4'h1; // RL2
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ss_take;
    take && !ss_dis;
  endsequence

  sequence msg_final;
    ss_take ##0 (slot_q == SLOT_LAST);
  endsequence

  start_bit_set_a: assert property ( // RL3
    ss_take ##0 (slot_q == 4'h0) |=> nibble_valid && nibble_value[3])
    else $error("start bit missing in first frame");

  start_bit_clr_a: assert property ( // RL3
    ss_take ##0 (slot_q != 4'h0) |=> !nibble_value[3])
    else $error("start bit set outside first frame");

  msg_id_wrap_a: assert property ( // RL2
    msg_final ##0 (msg_id_q == MSG_ID_LAST) |=> (msg_id_q == 4'h0) && (slot_q == 4'h0))
    else $error("message id did not wrap after id four");

  msg_hold_a: assert property ( // RL19
    ss_take ##0 (slot_q != 4'h0) |=> $stable(msg_q) && $stable(msg_crc_q))
    else $error("slow message changed mid sequence");

  ss_off_a: assert property ( // RL1
    take && ss_dis && !(shared && addr_in) |=> nibble_value[3:2] == 2'b00)
    else $error("slow channel bits active while disabled");

  addr_status_a: assert property ( // RL8
    take && ss_dis && shared && addr_in |=> nibble_value[3:2] == $past(bus_addr))
    else $error("bus address missing from status bits");

  status_code_a: assert property ( // RL17
    take |=> nibble_value[1:0] == $past(device_status))
    else $error("status low bits differ from device status");

  cnt_wrap_a: assert property ( // RL11
    take && (layout == LAYOUT_FLAGS) && (cnt_q == CNT_MAX_SHORT) |=> cnt_q == 12'h000)
    else $error("short frame counter did not wrap");

  frame_len_a: assert property ( // RL10
    nibble_last |-> ((len_q == LEN_SHORT) ? (idx_q == 4'h4) : (idx_q == 4'h7)))
    else $error("frame nibble count wrong");

  crc_seed_a: assert property ( // RL14
    take && (layout == LAYOUT_FIELD) && !(shared && scn_crc)
      |=> seq_q[4] == crc_step(crc_step(crc_step(CRC_SEED, seq_q[1]), seq_q[2]), seq_q[3]))
    else $error("frame crc mismatch");

  fall_sel_a: assert property ( // RL16
    wr_acc && (addr8 == CFG_OFS) && !err_q && pstrb[0]
      |=> fall_time_sel == $past(pwdata[CFG_FALL_LSB +: 3]))
    else $error("fall-time code not taken from write");

  tick_code_a: assert property ( // RL18
    nibble_valid |-> nibble_low_ticks == 3'h5 && nibble_high_ticks == 5'(nibble_value + 7))
    else $error("nibble tick counts wrong");

endmodule : sent_frame_payload_builder

//--- tb/sent_nibble_sink.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// tick generator stand-in: takes nibbles, may stall every other cycle
// ----------------------------------------------------------------
module sent_nibble_sink (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic        nibble_valid,
  input  wire logic [3:0]  nibble_value,
  input  wire logic        nibble_last,
  output logic             nibble_ready,
  output logic [31:0]      frame_q,
  output logic [3:0]       len_q,
  output logic             done_q
);
  logic       hold_q;
  logic [3:0] count_q;

  assign nibble_ready = ~hold_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q  <= 1'h0;
      count_q <= 4'h0;
      len_q   <= 4'h0;
      done_q  <= 1'h0;
      frame_q <= 32'h0000_0000;
    end else begin
      hold_q <= stall & ~hold_q;
      done_q <= 1'h0;
      if (nibble_valid && nibble_ready) begin
        frame_q[{count_q[2:0], 2'h0} +: 4] <= nibble_value;
        count_q <= nibble_last ? 4'h0 : count_q + 4'h1;
        done_q  <= nibble_last;
        if (nibble_last) begin
          len_q <= count_q + 4'h1;
        end
      end
    end
  end
endmodule : sent_nibble_sink

//--- tb/tb_sent_frame_payload_builder.sv
`timescale 1ns/100ps
module tb_sent_frame_payload_builder
  import sent_payload_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_start;
  logic [11:0] mag_out;
  logic [7:0]  diag_flags;
  logic [11:0] temp_out;
  logic [1:0]  device_status;
  logic        nibble_valid;
  logic        nibble_ready;
  logic [3:0]  nibble_value;
  logic        nibble_last;
  logic [2:0]  nibble_low_ticks;
  logic [4:0]  nibble_high_ticks;
  logic [2:0]  fall_time_sel;
  logic        stall;
  logic [31:0] frame_w;
  logic [3:0]  len;
  logic        done;
  int          failures;
  int          tests_run;
  logic [11:0] cnt_exp;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  b;
  logic [3:0]  cs;
  logic [15:0] w;
  logic [19:0] frame_exp;

  sent_frame_payload_builder #(.ADDR_W(8)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_start(frame_start), .mag_out(mag_out),
    .diag_flags(diag_flags), .temp_out(temp_out), .device_status(device_status),
    .nibble_valid(nibble_valid), .nibble_ready(nibble_ready), .nibble_value(nibble_value),
    .nibble_last(nibble_last), .nibble_low_ticks(nibble_low_ticks),
    .nibble_high_ticks(nibble_high_ticks), .fall_time_sel(fall_time_sel));

  sent_nibble_sink sink (
    .pclk(pclk), .presetn(presetn), .stall(stall), .nibble_valid(nibble_valid),
    .nibble_value(nibble_value), .nibble_last(nibble_last), .nibble_ready(nibble_ready),
    .frame_q(frame_w), .len_q(len), .done_q(done));

  always #25 pclk = ~pclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] crc4(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      r = (r[3] ^ n[i]) ? ({r[2:0], 1'h0} ^ 4'hd) : {r[2:0], 1'h0};
    end
    return r;
  endfunction : crc4

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask : apb

  task automatic frame(input logic [3:0] st, input logic [1:0] lay, input logic scn);
    logic [3:0] d [0:5];
    logic [3:0] c;
    int         n;
    int         i;
    n = (lay == 2'h0) ? 3 : 6;
    d[0] = mag_out[11:8];
    d[1] = mag_out[7:4];
    d[2] = mag_out[3:0];
    d[3] = (lay == 2'h1) ? diag_flags[7:4] : (lay == 2'h2) ? cnt_exp[11:8] : temp_out[11:8];
    d[4] = (lay == 2'h1) ? diag_flags[3:0] : (lay == 2'h2) ? cnt_exp[7:4] : temp_out[7:4];
    d[5] = (lay == 2'h3) ? temp_out[3:0] : cnt_exp[3:0];
    c = scn ? crc4(4'h5, st) : 4'h5;
    for (i = 0; i < n; i++) begin
      c = crc4(c, d[i]);
    end
    @(posedge pclk);
    frame_start <= 1'h1;
    stall       <= cnt_exp[0];
    @(posedge pclk);
    frame_start <= 1'h0;
    #1;
    chk("low ticks", 32'(3'h5), 32'(nibble_low_ticks));
    chk("high ticks", 32'(st) + 32'(4'h7), 32'(nibble_high_ticks));
    i = 0;
    while (done !== 1'h1 && i < 100) begin
      @(posedge pclk);
      #1;
      i++;
    end
    chk("frame done", 32'h0000_0001, 32'(done));
    chk("nibble count", 32'(n + 2), 32'(len));
    chk("status nibble", 32'(st), 32'(frame_w[3:0]));
    for (i = 0; i < n; i++) begin
      chk("data nibble", 32'(d[i]), 32'(frame_w[4*i+4 +: 4]));
    end
    chk("crc nibble", 32'(c), 32'(frame_w[4*n+4 +: 4]));
    frame_exp = {c, d[2], d[1], d[0], st};
    cnt_exp = (lay == 2'h1 && cnt_exp == 12'h00f) ? 12'h000 : cnt_exp + 12'h001;
  endtask : frame

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    paddr = 8'h00;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    pwdata = 32'h0000_0000;
    frame_start = 1'h0;
    mag_out = 12'ha5c;
    diag_flags = 8'ha5;
    temp_out = 12'hf04;
    device_status = 2'h1;
    stall = 1'h0;
    failures = 0;
    tests_run = 0;
    cnt_exp = 12'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h00, 32'h0000_0000);
    chk("cfg reset", 32'h0000_0000, rd);
    chk("fall reset", 32'h0000_0000, 32'(fall_time_sel));
    apb(1'h1, 8'h08, 32'h005a_c396);
    apb(1'h0, 8'h08, 32'h0000_0000);
    chk("cust id", 32'h005a_c396, rd);
    apb(1'h0, 8'h10, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(err));
    chk("unmapped data", 32'h0000_0000, rd);
    for (int m = 0; m < 5; m++) begin
      case (m)
        0: b = 8'ha5;
        1: b = 8'hfa;
        2: b = 8'h96;
        3: b = 8'hc3;
        default: b = 8'h5a;
      endcase
      cs = crc4(crc4(crc4(4'h5, 4'(m)), b[7:4]), b[3:0]);
      w = {4'(m), b, cs};
      for (int s = 0; s < 16; s++) begin
        if (m == 0 && s == 5) diag_flags <= 8'h3c;
        frame({(s == 0), w[15-s], 2'h1}, 2'h0, 1'h0);
      end
    end
    apb(1'h1, 8'h00, 32'h0000_00a0);
    chk("fall code", 32'h0000_0005, 32'(fall_time_sel));
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    cnt_exp = 12'h000;
    chk("fall after reset", 32'h0000_0000, 32'(fall_time_sel));
    mag_out <= 12'h3e7;
    apb(1'h1, 8'h00, 32'h0000_180b);
    for (int k = 0; k < 17; k++) begin
      frame(4'h1, 2'h1, 1'h0);
    end
    for (int k = 2; k < 5; k++) begin
      device_status <= 2'(k);
      apb(1'h1, 8'h00, 32'h0000_1809 | 32'(k % 4) << 1);
      frame({2'h0, 2'(k)}, 2'(k % 4), 1'h0);
    end
    apb(1'h1, 8'h00, 32'h0000_1909);
    frame({2'h3, 2'h0}, 2'h0, 1'h0);
    apb(1'h1, 8'h00, 32'h0000_0a19);
    frame({2'h1, 2'h0}, 2'h0, 1'h1);
    apb(1'h0, 8'h04, 32'h0000_0000);
    chk("stat reg", 32'(cnt_exp) << 8, rd);
    apb(1'h0, 8'h0c, 32'h0000_0000);
    chk("frame reg", 32'(frame_exp), rd & 32'h000f_ffff);
    summarize();
  end
endmodule : tb_sent_frame_payload_builder
